// [verilog/rbps_map.svh]
// Constants for the reset, boot and PLL sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef RBPS_MAP_SVH
`define RBPS_MAP_SVH
`define RBPS_CLK_MHZ        100
`define RBPS_RST_MIN_US     15
`define RBPS_RST_CYC        (`RBPS_RST_MIN_US * `RBPS_CLK_MHZ)
`define RBPS_GPIO_W         28
`define RBPS_SEC_OTP_BIT    5
`define RBPS_PLL_R_W        6
`define RBPS_PLL_F_W        12
`define RBPS_PLL_OD_W       3
`define RBPS_PLL_R_RST      6'h00
`define RBPS_PLL_F_RST      12'h000
`define RBPS_PLL_OD_RST     3'h0
`define RBPS_ADDR_PLLCFG    8'h00
`define RBPS_ADDR_STATUS    8'h04
`define RBPS_ADDR_SECURITY  8'h08
`define RBPS_CFG_R_LSB      0
`define RBPS_CFG_F_LSB      8
`define RBPS_CFG_OD_LSB     20
`endif

// [verilog/rbps_pkg.sv]
// Types for the reset, boot and PLL sequencer.
// Assumes the map header supplies numbers.
package rbps_pkg;
  typedef enum logic [4:0] {
    RBPS_HOLD   = 5'h01,
    RBPS_INTRST = 5'h02,
    RBPS_LOCK   = 5'h04,
    RBPS_BOOT   = 5'h08,
    RBPS_RUN    = 5'h10
  } rbps_state_t;
  typedef enum logic [1:0] {
    RBPS_SRC_0 = 2'h0,
    RBPS_SRC_1 = 2'h1,
    RBPS_SRC_2 = 2'h2,
    RBPS_SRC_OTP = 2'h3
  } rbps_src_t;
endpackage

// [verilog/rbps_sync3.sv]
// Three-stage synchroniser; output changes when stages two and three agree.
// Assumes one clock and asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module rbps_sync3
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  // Shift chain, then accept only agreed bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end
  assign dout = out_q;
endmodule
`default_nettype wire

// [verilog/rbps_sequencer.sv]
// Reset, boot-source and PLL configuration sequencer of a tile.
// Assumes pin inputs are asynchronous and the PLL reports lock.
// Function
// - PLL dividers writable through node register
// - Reset low holds chip, GPIO tri-stated
// - Internal reset interval, then pulls, boot speed
// - Upper mode straps select boot source
// - Security bit five forces OTP boot
// - Reset asserts immediately without clock
// - Wait for PLL lock before booting
`include "rbps_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rbps_sequencer
  import rbps_pkg::*;
#(
  parameter int RST_CYC = `RBPS_RST_CYC
)
(
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      boot_speed_strap_lo,
  input  wire logic                      boot_speed_strap_hi,
  input  wire logic [1:0]                bootSrcStrap,
  input  wire logic                      pllLock,
  input  wire logic [7:0]                regAddr,
  input  wire logic [31:0]               regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [31:0]               regRdata,
  output logic                           coreResetn,
  output logic                           gpioPullEn,
  output logic      [`RBPS_GPIO_W-1:0]   gpioOeMask,
  output logic                           pllRelock,
  output logic                           bootStart,
  output logic      [1:0]                bootSpeed,
  output logic      [1:0]                bootSource,
  output logic      [`RBPS_PLL_R_W-1:0]  pllInputDivider,
  output logic      [`RBPS_PLL_F_W-1:0]  pllFeedbackMult,
  output logic      [`RBPS_PLL_OD_W-1:0] pll_output_divider
);
  logic        rstMeta_q;
  logic        rstSync_q;
  logic [3:0]  pinSync;
  logic        lockSync;
  rbps_state_t state_q;
  rbps_state_t state_d;
  logic [31:0] cnt_q;
  logic [1:0]  speed_q;
  logic [1:0]  src_q;
  logic [31:0] sec_q;
  logic [`RBPS_PLL_R_W-1:0]  r_q;
  logic [`RBPS_PLL_F_W-1:0]  f_q;
  logic [`RBPS_PLL_OD_W-1:0] od_q;
  logic [31:0] rdata_q;
  logic        bootPulse_q;

  // Release of reset aligned to clk, assertion is immediate
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Straps and lock come from pins; board keeps straps steady
  rbps_sync3 #(.W(5)) uSync
  (
    .clk    (clk),
    .resetn (rstSync_q),
    .din    ({pllLock, bootSrcStrap, boot_speed_strap_hi,
              boot_speed_strap_lo}),
    .dout   ({lockSync, pinSync})
  );

  // Register decode
  wire wrCfg = regWr && (regAddr == `RBPS_ADDR_PLLCFG);
  wire wrSec = regWr && (regAddr == `RBPS_ADDR_SECURITY);
  wire otpForce = sec_q[`RBPS_SEC_OTP_BIT];
  wire cntDone = (cnt_q >= 32'(RST_CYC - 1));
  wire [31:0] cfgWord = (32'(r_q)  << `RBPS_CFG_R_LSB) |
                        (32'(f_q)  << `RBPS_CFG_F_LSB) |
                        (32'(od_q) << `RBPS_CFG_OD_LSB);
  wire [31:0] statWord = {21'h0, otpForce, src_q, speed_q,
                          lockSync, state_q};
  wire [31:0] rdSel = (regAddr == `RBPS_ADDR_PLLCFG)   ? cfgWord :
                      (regAddr == `RBPS_ADDR_STATUS)   ? statWord :
                      (regAddr == `RBPS_ADDR_SECURITY) ? sec_q : 32'h0;

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RBPS_HOLD:   state_d = RBPS_INTRST;
      RBPS_INTRST: if (cntDone) state_d = RBPS_LOCK;
      RBPS_LOCK:   if (lockSync) state_d = RBPS_BOOT;
      RBPS_BOOT:   state_d = RBPS_RUN;
      RBPS_RUN:    state_d = RBPS_RUN;
    endcase
  end

  // State, interval counter and boot latches
  always_ff @(posedge clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      state_q     <= RBPS_HOLD;
      cnt_q       <= 32'h0;
      speed_q     <= 2'h0;
      src_q       <= 2'h0;
      bootPulse_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= (state_q == RBPS_INTRST) ? cnt_q + 32'h1 : 32'h0;
      bootPulse_q <= (state_q == RBPS_LOCK) && lockSync;
      if ((state_q == RBPS_LOCK) && lockSync)
      begin
        speed_q <= pinSync[1:0];
        src_q   <= otpForce ? RBPS_SRC_OTP : pinSync[3:2];
      end
    end
  end

  // PLL and security registers; legal ranges are software's job
  always_ff @(posedge clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      r_q     <= `RBPS_PLL_R_RST;
      f_q     <= `RBPS_PLL_F_RST;
      od_q    <= `RBPS_PLL_OD_RST;
      sec_q   <= 32'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      if (wrCfg)
      begin
        r_q  <= regWdata[`RBPS_CFG_R_LSB +: `RBPS_PLL_R_W];
        f_q  <= regWdata[`RBPS_CFG_F_LSB +: `RBPS_PLL_F_W];
        od_q <= regWdata[`RBPS_CFG_OD_LSB +: `RBPS_PLL_OD_W];
      end
      if (wrSec)
        sec_q <= regWdata;
      rdata_q <= regRd ? rdSel : 32'h0;
    end
  end

  // Outputs
  assign regRdata   = rdata_q;
  assign coreResetn = (state_q == RBPS_RUN) || (state_q == RBPS_BOOT);
  assign gpioPullEn = !(state_q == RBPS_HOLD || state_q == RBPS_INTRST);
  assign gpioOeMask = '0; // pins undriven in every state, RBPS_RUN included
  assign pllRelock  = (state_q == RBPS_LOCK);
  assign bootStart  = bootPulse_q;
  assign bootSpeed  = speed_q;
  assign bootSource = src_q;
  assign pllInputDivider    = r_q;
  assign pllFeedbackMult    = f_q;
  assign pll_output_divider = od_q;

  // Boot never starts before interval and lock
  a_boot_after_lock: assert property (@(posedge clk) disable iff (!rstSync_q)
    $rose(bootPulse_q) |-> $past(lockSync) && $past(state_q) == RBPS_LOCK)
    else $error("boot without lock");
  a_otp_forced: assert property (@(posedge clk) disable iff (!rstSync_q)
    $rose(bootPulse_q) && $past(otpForce) |-> src_q == RBPS_SRC_OTP)
    else $error("otp not forced");
  a_src_strap: assert property (@(posedge clk) disable iff (!rstSync_q)
    $rose(bootPulse_q) && !$past(otpForce) |-> src_q == $past(pinSync[3:2]))
    else $error("wrong boot source");
  a_pull_timing: assert property (@(posedge clk) disable iff (!rstSync_q)
    state_q == RBPS_INTRST && !cntDone |=> !gpioPullEn)
    else $error("pull early");
  a_speed_strap: assert property (@(posedge clk) disable iff (!rstSync_q)
    $rose(bootPulse_q) |-> speed_q == $past(pinSync[1:0]))
    else $error("wrong boot speed");
  a_gpio_hiz: assert property (@(posedge clk) disable iff (!rstSync_q)
    state_q != RBPS_RUN |-> gpioOeMask == '0)
    else $error("gpio driven in reset");
  a_cfg_write: assert property (@(posedge clk) disable iff (!rstSync_q)
    wrCfg |=> f_q == $past(regWdata[`RBPS_CFG_F_LSB +: `RBPS_PLL_F_W]))
    else $error("pll write lost");
  a_core_held: assert property (@(posedge clk) disable iff (!rstSync_q)
    $past(state_q) == RBPS_HOLD |-> !coreResetn)
    else $error("core out of reset early");
endmodule
`default_nettype wire

// [bench/rbps_board.sv]
// Board model: reset source, mode straps and a PLL lock stand-in.
// Assumes the bench asks for reset and strap levels on clk.
`timescale 1ns/100ps
`default_nettype none
module rbps_board
(
  input  wire logic       clk,
  input  wire logic       rstReq,
  input  wire logic [3:0] strapReq,
  input  wire logic [7:0] lockDelay,
  input  wire logic       pllRelock,
  output logic            resetn,
  output logic      [3:0] straps,
  output logic            pllLock
);
  logic [3:0] lowCnt;
  logic [7:0] lockCnt;
  // Straps load only in reset, then stay put
  // Reset stays low 10 cycles past the request
  always_ff @(posedge clk or posedge rstReq)
    if (rstReq)
      lowCnt <= 4'h0;
    else if (lowCnt != 4'ha)
      lowCnt <= lowCnt + 4'h1;
  always_ff @(posedge clk)
    if (rstReq)
      straps <= strapReq;
  assign resetn = !rstReq && lowCnt == 4'ha;
  // Lock comes a set time after relock starts; lost in reset
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      lockCnt <= 8'h00;
    else if (pllRelock && lockCnt != 8'hff)
      lockCnt <= lockCnt + 8'h01;
  assign pllLock = resetn && lockCnt > lockDelay;
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the sequencer: boot table, then odd cases.
// Assumes the board model drives reset, straps and lock.
`include "rbps_map.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench
  import rbps_pkg::*;
;
  localparam int RST_CYC = 20;
  logic clk, rstReq, pllRelock, pllLock, resetn, regWr, regRd, bootStart;
  logic coreResetn, gpioPullEn;
  logic [3:0]  strapReq, straps;
  logic [7:0]  lockDelay, regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [27:0] oeMask;
  logic [1:0]  spd, src;
  logic [5:0]  pllR;
  logic [11:0] pllF;
  logic [2:0]  pllOd;
  int nErrors, nChecks, cyc, relCnt;
  // Rows: lock delay, otp, hi, lo, src strap, speed, source
  logic [16:0] rows [5] = '{17'h00800, 17'h00855, 17'h008aa,
                            17'h008ff, 17'h07957};
  rbps_board board (.clk(clk), .rstReq(rstReq), .strapReq(strapReq),
    .lockDelay(lockDelay), .pllRelock(pllRelock), .resetn(resetn),
    .straps(straps), .pllLock(pllLock));
  rbps_sequencer #(.RST_CYC(RST_CYC)) DUT (.clk(clk), .resetn(resetn),
    .boot_speed_strap_lo(straps[2]), .boot_speed_strap_hi(straps[3]),
    .bootSrcStrap(straps[1:0]), .pllLock(pllLock), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .coreResetn(coreResetn),
    .gpioPullEn(gpioPullEn), .gpioOeMask(oeMask), .pllRelock(pllRelock),
    .bootStart(bootStart), .bootSpeed(spd), .bootSource(src),
    .pllInputDivider(pllR), .pllFeedbackMult(pllF),
    .pll_output_divider(pllOd));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    nChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cycle count since reset release, and the hang limit
  always @(posedge clk)
  begin
    relCnt = resetn ? relCnt + 1 : 0;
    cyc++;
    if (cyc == 20000)
    begin
      nErrors++;
      give_verdict();
    end
  end
  initial
  begin
    {rstReq, regWr, regRd, regAddr, regWdata} = '0;
    {strapReq, lockDelay} = '0;
    rstReq = 1'b1;
    foreach (rows[i])
    begin
      @(posedge clk);
      rstReq <= 1'b1;
      strapReq <= rows[i][7:4];
      lockDelay <= rows[i][16:9];
      repeat (5) @(posedge clk);
      #1 chk("held", 0, {oeMask, coreResetn, gpioPullEn});
      chk("pll reset", 0, {pllR, pllF, pllOd});
      rstReq <= 1'b0;
      while (resetn !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      wr(`RBPS_ADDR_SECURITY, 32'(rows[i][8]) << `RBPS_SEC_OTP_BIT);
      for (int k = 0; k < 400 && bootStart !== 1'b1; k++)
        @(posedge clk) #1;
      chk("boot wait", 1, relCnt >= RST_CYC + rows[i][16:9]);
      chk("pulls", 1, {gpioPullEn, coreResetn, pllLock} == 3'h7);
      chk("speed", rows[i][3:2], spd);
      chk("source", rows[i][1:0], src);
    end
    // Legal PLL setting after boot, read back, then rdata back to zero when idle
    wr(`RBPS_ADDR_PLLCFG, 32'h0050c703);
    #1 chk("pll", {6'h03, 12'h0c7, 3'h5}, {pllR, pllF, pllOd});
    rdReg(`RBPS_ADDR_PLLCFG);
    chk("pllcfg", 32'h0050c703, rd);
    @(posedge clk) #1 chk("rdata idle", 0, regRdata);
    // Status after the last row: run, lock, speed 1, forced source
    rdReg(`RBPS_ADDR_STATUS);
    chk("status", 32'h00000770, rd);
    rdReg(`RBPS_ADDR_SECURITY);
    chk("security", 32'h00000020, rd);
    rdReg(8'h40);
    chk("unmapped", 0, rd);
    // Reset request between edges must take hold at once
    @(posedge clk);
    #3 rstReq = 1'b1;
    #1 chk("async", 0, {coreResetn, oeMask});
    give_verdict();
  end
endmodule
`default_nettype wire
